// ==== src/lst_startup.sv ====
// start-up transition logic with avalon register slave
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lst_startup
  import lst_pkg::*;
#(
  parameter logic [31:0] TIMER_CYCLES = STARTUP_CYCLES
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [3:0]  av_byteenable,
  input  wire logic [31:0] av_writedata,
  output logic [31:0]      av_readdata,
  output logic             av_waitrequest,
  // received control bytes
  input  wire logic        rx_ctrl_valid,
  input  wire logic [7:0]  rx_ctrl_idx,
  input  wire logic [7:0]  rx_ctrl_byte,
  // transmitted control bytes
  input  wire logic [7:0]  tx_ctrl_idx,
  output logic [7:0]       tx_ctrl_byte,
  // line status
  input  wire logic        hyperframe_sync,
  input  wire logic        line_rate_match,
  input  wire logic        signal_absent,
  input  wire logic        frame_lock_lost,
  input  wire logic        remote_alarm_flag,
  input  wire logic        slave_in_negotiation,
  // application triggers
  input  wire logic        app_new_mgmt_rate,
  input  wire logic        app_accept,
  input  wire logic        app_renegotiate,
  input  wire logic        app_mgmt_lost,
  input  wire logic        app_new_proto_rate,
  // status
  output logic [2:0]       state_code,
  output logic             scramble_on
);
  // ****************************************************
  // declarations
  // ****************************************************
  lst_timer_if tif ();
  lst_state_t  state_reg;
  lst_state_t  state_next;
  logic [31:0] ctrl_reg;
  logic [31:0] txcfg_reg;
  logic [31:0] allow_reg;
  logic [31:0] timer_reg;
  logic        init_reg;
  logic        slave_seen_reg;
  logic [7:0]  rx_proto_reg;
  logic [7:0]  rx_slow_reg;
  logic [7:0]  rx_fast_reg;
  logic        proto_seen_reg;
  logic        slow_seen_reg;
  logic        fast_seen_reg;
  logic        proto_chg_reg;
  logic        rate_chg_reg;
  logic        tmr_start;
  logic        tmr_clear;
  logic        bus_req;
  logic        bus_ack;
  logic [31:0] rd_value;
  logic        is_master;
  logic        cfg_valid;
  logic        fault;
  logic        proto_eq;
  logic        slow_eq;
  logic        fast_eq;
  logic        rate_agreed;
  logic        tx_rates_zero;
  logic        rx_rates_zero;
  logic [7:0]  rx_masked;
  logic [7:0]  tx_proto;
  logic [7:0]  tx_slow;
  logic [7:0]  tx_fast;

  // ****************************************************
  // start-up timer
  // ****************************************************
  lst_timer u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tif     (tif.tmr)
  );
  assign tif.start = tmr_start;
  assign tif.clear = tmr_clear;
  assign tif.load  = timer_reg;

  // ****************************************************
  // avalon slave: one wait cycle on every access
  // ****************************************************
  assign bus_req = av_read || av_write;
  assign bus_ack = bus_req && !av_waitrequest;

  // waitrequest drops for exactly the accepting edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      av_waitrequest <= 1'b1;
    end else if (bus_req && av_waitrequest) begin
      av_waitrequest <= 1'b0;
    end else begin
      av_waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (av_address)
      REG_CTRL:   rd_value = ctrl_reg;
      REG_TXCFG:  rd_value = txcfg_reg;
      REG_ALLOW:  rd_value = allow_reg;
      REG_TIMER:  rd_value = timer_reg;
      REG_STATUS: rd_value = {16'h0000, rx_proto_reg, 1'b0,
                              slave_seen_reg, scramble_on,
                              tif.expired, tif.running,
                              state_code};
      default:    rd_value = 32'h0000_0000;
    endcase
  end

  // read data loaded so it stands on the accepting edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      av_readdata <= 32'h0000_0000;
    end else if (av_read && av_waitrequest) begin
      av_readdata <= rd_value;
    end
  end

  // configuration writes; init bit is not stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg  <= CTRL_RST;
      txcfg_reg <= TXCFG_RST;
      allow_reg <= ALLOW_RST;
      timer_reg <= TIMER_CYCLES;
    end else if (bus_ack && av_write) begin
      case (av_address)
        REG_CTRL: begin
          ctrl_reg <= be_merge(ctrl_reg, av_writedata,
                               av_byteenable) & 32'h0000_0007;
        end
        REG_TXCFG: begin
          txcfg_reg <= be_merge(txcfg_reg, av_writedata,
                                av_byteenable);
        end
        REG_ALLOW: begin
          allow_reg <= be_merge(allow_reg, av_writedata,
                                av_byteenable);
        end
        REG_TIMER: begin
          timer_reg <= be_merge(timer_reg, av_writedata,
                                av_byteenable);  // see RULE27
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  // port initialisation pulse from a control write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      init_reg <= 1'b0;
    end else begin
      init_reg <= bus_ack && av_write &&
                  av_address == REG_CTRL && av_byteenable[0] &&
                  av_writedata[CTRL_INIT];
    end
  end

  // ****************************************************
  // received control bytes
  // ****************************************************
  // rate bytes are masked so reserved bits never count
  always_comb begin
    case (rx_ctrl_idx)
      IDX_SLOW: rx_masked = rx_ctrl_byte & SLOW_MASK; // see RULE19
      IDX_FAST: rx_masked = rx_ctrl_byte & FAST_MASK; // see RULE19
      default:  rx_masked = rx_ctrl_byte;
    endcase
  end

  // capture by fixed position; reserved words dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n || init_reg) begin
      rx_proto_reg   <= 8'h00;
      rx_slow_reg    <= 8'h00;
      rx_fast_reg    <= 8'h00;
      proto_seen_reg <= 1'b0;
      slow_seen_reg  <= 1'b0;
      fast_seen_reg  <= 1'b0;
      proto_chg_reg  <= 1'b0;
      rate_chg_reg   <= 1'b0;
    end else begin
      proto_chg_reg <= 1'b0;
      rate_chg_reg  <= 1'b0;
      if (rx_ctrl_valid && !subch_reserved(rx_ctrl_idx)) begin
        case (rx_ctrl_idx)                      // see RULE20
          IDX_PROTO: begin                      // see RULE18
            proto_chg_reg  <= proto_seen_reg &&
                              rx_masked != rx_proto_reg;
            rx_proto_reg   <= rx_masked;
            proto_seen_reg <= 1'b1;
          end
          IDX_SLOW: begin
            rate_chg_reg  <= slow_seen_reg &&
                             rx_masked != rx_slow_reg;
            rx_slow_reg   <= rx_masked;
            slow_seen_reg <= 1'b1;
          end
          IDX_FAST: begin
            rate_chg_reg  <= fast_seen_reg &&
                             rx_masked != rx_fast_reg;
            rx_fast_reg   <= rx_masked;
            fast_seen_reg <= 1'b1;
          end
          default: begin
            rate_chg_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************
  // agreement and condition terms
  // ****************************************************
  assign is_master = ctrl_reg[CTRL_MASTER];
  assign tx_proto  = txcfg_reg[7:0];
  assign tx_slow   = txcfg_reg[15:8] & SLOW_MASK;
  assign tx_fast   = txcfg_reg[23:16] & FAST_MASK;
  // all three allowed sets must be non-empty
  assign cfg_valid = |allow_reg[7:0] && |allow_reg[15:8] &&
                     |allow_reg[23:16];         // see RULE2
  assign fault     = signal_absent || frame_lock_lost ||
                     remote_alarm_flag;
  // any difference in version means incompatible
  assign proto_eq  = proto_seen_reg &&
                     tx_proto == rx_proto_reg;  // see RULE22
  // a zero rate byte never counts as agreement
  assign slow_eq   = slow_seen_reg && tx_slow == rx_slow_reg &&
                     rx_slow_reg != 8'h00;      // see RULE5
  assign fast_eq   = fast_seen_reg && tx_fast == rx_fast_reg &&
                     rx_fast_reg != 8'h00;      // see RULE5
  assign rate_agreed   = slow_eq || fast_eq;
  assign tx_rates_zero = tx_slow == 8'h00 && tx_fast == 8'h00;
  assign rx_rates_zero = slow_seen_reg && fast_seen_reg &&
                         rx_slow_reg == 8'h00 &&
                         rx_fast_reg == 8'h00;

  // slave negotiation reached since reset, held until reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slave_seen_reg <= 1'b0;
    end else if (slave_in_negotiation) begin
      slave_seen_reg <= 1'b1;                   // see RULE1
    end
  end

  // ****************************************************
  // transition logic; a transition fires once since the
  // state change removes its own trigger
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    tmr_start  = 1'b0;
    tmr_clear  = 1'b0;
    if (init_reg) begin
      state_next = ST_STANDBY;
      tmr_clear  = 1'b1;                        // see RULE12
    end else if (fault && state_reg != ST_STANDBY &&
                 state_reg != ST_LINE_SYNC) begin
      state_next = ST_LINE_SYNC;
      tmr_clear  = 1'b1;                        // see RULE11
    end else begin
      case (state_reg)                          // see RULE28
        ST_STANDBY: begin
          if (ctrl_reg[CTRL_START] && cfg_valid &&
              !(is_master && ctrl_reg[CTRL_RADIO] &&
                !slave_seen_reg)) begin         // see RULE1
            state_next = ST_LINE_SYNC;
          end
        end
        ST_LINE_SYNC: begin
          if (hyperframe_sync && line_rate_match) begin
            state_next = ST_PROTO;
            tmr_start  = 1'b1;                  // see RULE3
          end
        end
        ST_PROTO: begin
          if (tif.expired) begin
            state_next = ST_LINE_SYNC;          // see RULE17
          end else if (proto_eq) begin
            state_next = ST_MGMT;               // see RULE4
          end
        end
        ST_MGMT: begin
          if (proto_chg_reg) begin
            state_next = ST_PROTO;
            tmr_start  = 1'b1;                  // see RULE14
          end else if (!proto_eq) begin
            state_next = ST_PROTO;              // see RULE23
          end else if (tif.expired) begin
            state_next = ST_LINE_SYNC;          // see RULE17
          end else if (is_master ? tx_rates_zero
                                 : rx_rates_zero) begin
            state_next = ST_PASSIVE;
            tmr_clear  = 1'b1;                  // see RULE15
          end else if (rate_agreed) begin
            state_next = ST_NEGOT;              // see RULE5
          end
        end
        ST_NEGOT, ST_OPER: begin
          if (proto_chg_reg) begin
            state_next = ST_PROTO;
            tmr_start  = 1'b1;                  // see RULE14
          end else if (!proto_eq) begin
            state_next = ST_PROTO;              // see RULE23
          end else if (app_new_proto_rate) begin
            // allowed sets stay in place for the restart
            state_next = ST_LINE_SYNC;
            tmr_clear  = 1'b1;                  // see RULE10
          end else if (rate_chg_reg) begin
            state_next = ST_MGMT;
            tmr_start  = 1'b1;                  // see RULE13
          end else if (app_mgmt_lost) begin
            state_next = ST_MGMT;
            tmr_start  = 1'b1;                  // see RULE9
          end else if (app_new_mgmt_rate) begin
            state_next = ST_MGMT;
            tmr_start  = 1'b1;                  // see RULE6
          end else if (!rate_agreed) begin
            state_next = ST_MGMT;               // see RULE24
          end else if (state_reg == ST_NEGOT && app_accept) begin
            state_next = ST_OPER;
            tmr_clear  = 1'b1;                  // see RULE7
          end else if (state_reg == ST_OPER &&
                       app_renegotiate) begin
            state_next = ST_NEGOT;              // see RULE8
          end
        end
        ST_PASSIVE: begin
          if (proto_chg_reg) begin
            state_next = ST_PROTO;
            tmr_start  = 1'b1;                  // see RULE14
          end else if (!proto_eq) begin
            state_next = ST_PROTO;              // see RULE23
          end else if (is_master ? !tx_rates_zero
                                 : rate_chg_reg) begin
            state_next = ST_MGMT;               // see RULE26
            tmr_start  = 1'b1;                  // see RULE16
          end
        end
        default: begin
          state_next = ST_STANDBY;
          tmr_clear  = 1'b1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // transmit byte for the requested word position
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_ctrl_byte <= 8'h00;
    end else if (subch_reserved(tx_ctrl_idx)) begin
      tx_ctrl_byte <= 8'h00;                    // see RULE20
    end else begin
      case (tx_ctrl_idx)                        // see RULE18
        IDX_PROTO: tx_ctrl_byte <= tx_proto;
        IDX_SLOW: begin
          // passive master asks for no channel
          tx_ctrl_byte <= (state_reg == ST_PASSIVE && is_master)
                          ? 8'h00 : tx_slow;    // see RULE25
        end
        IDX_FAST: begin
          tx_ctrl_byte <= (state_reg == ST_PASSIVE && is_master)
                          ? 8'h00 : tx_fast;    // see RULE25
        end
        default: tx_ctrl_byte <= 8'h00;         // see RULE19
      endcase
    end
  end

  // state code and scrambling mode of the agreed version
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_code  <= 3'h0;
      scramble_on <= 1'b0;
    end else begin
      state_code  <= state_next;
      scramble_on <= proto_eq &&
                     rx_proto_reg == PROTO_SCRAMBLE; // see RULE21
    end
  end
endmodule // lst_startup
`default_nettype wire

// ==== src/lst_pkg.sv ====
// constants and types for the link start-up transition block
//
// Functional notes
// RULE1 - radio node master waits for slave negotiation
// RULE2 - allowed rate and version sets before start
// RULE3 - start timer entering hyperframe sync
// RULE4 - equal protocol bytes agree protocol, no timer
// RULE5 - matching valid rate byte agrees channel
// RULE6 - new application channel rate starts timer
// RULE7 - accepted negotiation enters operation, clears timer
// RULE8 - renegotiation returns to negotiation, no timer
// RULE9 - lost management connection starts timer
// RULE10 - new protocol or rate restarts, clears timer
// RULE11 - line fault clears timer
// RULE12 - port initialisation clears timer
// RULE13 - received rate change in E/F starts timer
// RULE14 - received version change starts timer
// RULE15 - master requests no channel: passive, clear
// RULE16 - master proposes a rate: timer starts
// RULE17 - timer expiry itself causes a transition
// RULE18 - sync, version, hyperframe byte positions fixed
// RULE19 - send reserved bits zero, ignore on receive
// RULE20 - subchannels 3 and 8-15 fully reserved
// RULE21 - version one unscrambled, two scrambled
// RULE22 - unequal versions are incompatible
// RULE23 - version mismatch returns to protocol setup
// RULE24 - no matching rate byte returns to setup
// RULE25 - passive master sends zero rate bytes
// RULE26 - passive slave leaves on received rate change
// RULE27 - timer length is a configurable cycle count
// RULE28 - seven states, first trigger takes transition
package lst_pkg;
  // ****************************************************
  // register map (byte addresses)
  // ****************************************************
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_TXCFG  = 5'h04;
  localparam logic [4:0] REG_ALLOW  = 5'h08;
  localparam logic [4:0] REG_TIMER  = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam int CTRL_START  = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_RADIO  = 2;
  localparam int CTRL_INIT   = 3;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] TXCFG_RST = 32'h0000_0000;
  localparam logic [31:0] ALLOW_RST = 32'h0000_0000;
  // ****************************************************
  // control byte positions in the hyperframe
  // ****************************************************
  localparam logic [7:0] IDX_SYNC      = 8'h00;
  localparam logic [7:0] IDX_PROTO     = 8'h02;
  localparam logic [7:0] IDX_HYPER_NUM = 8'h40;
  localparam logic [7:0] IDX_SLOW      = 8'h42;
  localparam logic [7:0] IDX_FAST      = 8'hC2;
  localparam logic [7:0] SLOW_MASK     = 8'h07;
  localparam logic [7:0] FAST_MASK     = 8'h3F;
  localparam logic [7:0] PROTO_SCRAMBLE = 8'h02;
  localparam logic [31:0] STARTUP_CYCLES = 32'h0010_0000;
  typedef enum logic [2:0] {
    ST_STANDBY, ST_LINE_SYNC, ST_PROTO, ST_MGMT,
    ST_NEGOT, ST_OPER, ST_PASSIVE
  } lst_state_t;
  // subchannel 3 and 8..15 words carry only reserved bits
  function automatic logic subch_reserved(input logic [7:0] idx);
    return (idx[5:0] == 6'h03) ||
           (idx[5:0] >= 6'h08 && idx[5:0] <= 6'h0F);
  endfunction
  // byte-enable merge of a 32-bit write
  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction
endpackage

// ==== src/lst_timer_if.sv ====
// start-up timer carrier between state logic and counter
`timescale 1ns/100ps
`default_nettype none
interface lst_timer_if;
  logic        start;
  logic        clear;
  logic [31:0] load;
  logic        running;
  logic        expired;
  modport ctrl (output start, output clear, output load,
                input running, input expired);
  modport tmr  (input start, input clear, input load,
                output running, output expired);
endinterface
`default_nettype wire

// ==== src/lst_timer.sv ====
// start-up timer: down counter with sticky expiry flag
`timescale 1ns/100ps
`default_nettype none
module lst_timer
  import lst_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control side
  lst_timer_if.tmr tif
);
  logic [31:0] cnt_reg;
  logic        run_reg;
  logic        exp_reg;

  // clear beats start so an init or fault always wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n || tif.clear) begin
      cnt_reg <= 32'h0000_0000;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else if (tif.start) begin
      cnt_reg <= tif.load;                      // see RULE27
      run_reg <= 1'b1;
      exp_reg <= 1'b0;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 32'h0000_0001;
      if (cnt_reg <= 32'h0000_0001) begin
        run_reg <= 1'b0;
        exp_reg <= 1'b1;                        // see RULE27
      end
    end
  end

  assign tif.running = run_reg;
  assign tif.expired = exp_reg;
endmodule // lst_timer
`default_nettype wire

// ==== test/lst_assertions.sv ====
// port checks for the start-up transition block
`timescale 1ns/100ps
`default_nettype none
module lst_assertions (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // bus handshake
  input wire logic       av_read,
  input wire logic       av_write,
  input wire logic       av_waitrequest,
  // link and status
  input wire logic [7:0] tx_ctrl_idx,
  input wire logic [7:0] tx_ctrl_byte,
  input wire logic       signal_absent,
  input wire logic       frame_lock_lost,
  input wire logic       remote_alarm_flag,
  input wire logic [2:0] state_code,
  input wire logic       scramble_on
);
  // ***
  // checks
  // ***
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic fault_any;
  logic idx_resv;
  // line fault; reserved word index
  assign fault_any = signal_absent | frame_lock_lost | remote_alarm_flag;
  assign idx_resv  = tx_ctrl_idx[5:0] == 6'h03 || tx_ctrl_idx[5:3] == 3'h1;
  // one cycle of wait low per request
  sequence s_req;
    $rose(av_read) || $rose(av_write);
  endsequence
  sequence s_ans;
    !av_waitrequest ##1 av_waitrequest;
  endsequence
  bus_answer_a: assert property (s_req |=> s_ans)
    else $error("bus answer late");
  reset_state_a: assert property (
    $rose(rst_n) |-> state_code == 3'h0 && !scramble_on)
    else $error("reset state wrong");
  standby_exit_a: assert property (
    $past(state_code) == 3'h0 && state_code != 3'h0 |-> state_code == 3'h1)
    else $error("bad standby exit");
  oper_entry_a: assert property (
    state_code == 3'h5 |-> $past(state_code) inside {3'h4, 3'h5})
    else $error("bad operation entry");
  negot_entry_a: assert property (
    state_code == 3'h4 |-> $past(state_code) inside {3'h3, 3'h4, 3'h5})
    else $error("bad negotiation entry");
  passive_entry_a: assert property (
    state_code == 3'h6 |-> $past(state_code) inside {3'h3, 3'h6})
    else $error("bad passive entry");
  fault_exit_a: assert property (
    fault_any && state_code > 3'h1 |-> ##[1:4] state_code <= 3'h1)
    else $error("fault not handled");
  reserved_tx_a: assert property (
    idx_resv |=> tx_ctrl_byte == 8'h00)
    else $error("reserved word nonzero");
endmodule  // lst_assertions
bind lst_startup lst_assertions u_lst_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .av_read(av_read),
  .av_write(av_write), .av_waitrequest(av_waitrequest),
  .tx_ctrl_idx(tx_ctrl_idx), .tx_ctrl_byte(tx_ctrl_byte),
  .signal_absent(signal_absent), .frame_lock_lost(frame_lock_lost),
  .remote_alarm_flag(remote_alarm_flag), .state_code(state_code),
  .scramble_on(scramble_on));
`default_nettype wire

// ==== test/lst_peer.sv ====
// peer port model
`timescale 1ns/100ps
`default_nettype none
module lst_peer (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // advertised bytes
  input  wire logic [7:0] p_ver,
  input  wire logic [7:0] p_slow,
  input  wire logic [7:0] p_fast,
  // link to the port
  output logic            rx_ctrl_valid,
  output logic [7:0]      rx_ctrl_idx,
  output logic [7:0]      rx_ctrl_byte
);
  logic [1:0] slot_reg;
  // one byte a cycle; reserved word all zero
  always_ff @(posedge ref_clk) begin
    slot_reg      <= rst_n ? slot_reg + 2'h1 : 2'h0;
    rx_ctrl_valid <= rst_n;
    case (slot_reg)
      2'h0: {rx_ctrl_idx, rx_ctrl_byte} <= {8'h02, p_ver};
      2'h1: {rx_ctrl_idx, rx_ctrl_byte} <= {8'h42, p_slow};
      2'h2: {rx_ctrl_idx, rx_ctrl_byte} <= {8'hC2, p_fast};
      default: {rx_ctrl_idx, rx_ctrl_byte} <= 16'h0300;
    endcase
  end
endmodule  // lst_peer
`default_nettype wire

// ==== test/tb_link_startup_transitions.sv ====
// bench for the start-up transition block
`timescale 1ns/100ps
`default_nettype none
module tb_link_startup_transitions import lst_pkg::*;;
  localparam logic [31:0] TC = 32'h0000_003C;
  typedef struct { logic [4:0] a; logic [31:0] w, r; } lst_reg_t;
  typedef struct { int op; logic [7:0] v; logic [2:0] st; int tm; } lst_step_t;
  // ***
  // wiring
  // ***
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  av_address = 5'h00;
  logic        av_read = 1'b0;
  logic        av_write = 1'b0;
  logic [31:0] av_writedata = 32'h0;
  logic [31:0] av_readdata, q;
  logic        av_waitrequest, rx_v, scramble_on, hsync = 1'b0;
  logic [7:0]  rx_i, rx_b, tx_b, tx_i = 8'h00, p_ver = 8'h01, p_slow = 8'h00;
  logic [2:0]  fault = 3'h0, state_code;
  logic [4:0]  app = 5'h00;
  int          fails = 0, n_checks = 0, cyc = 0;
  lst_reg_t rr[] = '{'{REG_CTRL, 32'h0, CTRL_RST}, '{REG_TXCFG, 32'h0, TXCFG_RST},
    '{REG_ALLOW, 32'h0, ALLOW_RST}, '{REG_TIMER, 32'h0, TC}};
  lst_reg_t rw[] = '{'{REG_TXCFG, 32'h0001_0302, 32'h0001_0302},
    '{REG_ALLOW, 32'h0001_0101, 32'h0001_0101}, '{REG_TIMER, TC, TC},
    '{5'h14, 32'hFFFF_FFFF, 32'h0},
    '{REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0100},
    '{REG_CTRL, 32'h1, 32'h1}};
  lst_step_t sr[] = '{'{3, 8'h01, 3'h2, 1},
    '{0, 8'h02, 3'h3, 2}, '{9, 8'h00, 3'h6, 0},
    '{1, 8'h03, 3'h3, 2}, '{9, 8'h00, 3'h4, 1},
    '{4, 8'h08, 3'h5, 0}, '{4, 8'h04, 3'h4, 0},
    '{4, 8'h02, 3'h3, 2}, '{9, 8'h00, 3'h4, 1},
    '{1, 8'h05, 3'h3, 1}, '{1, 8'h03, 3'h4, 2},
    '{4, 8'h10, 3'h3, 2}, '{9, 8'h00, 3'h4, 1},
    '{0, 8'h01, 3'h2, 1}, '{9, 8'h00, 3'h1, 2},
    '{0, 8'h02, 3'h4, 2}, '{4, 8'h01, 3'h1, 2},
    '{9, 8'h00, 3'h4, 2}, '{5, 8'h04, 3'h1, 0}, '{5, 8'h00, 3'h4, 2},
    '{5, 8'h02, 3'h1, 0}, '{5, 8'h00, 3'h4, 2},
    '{5, 8'h01, 3'h1, 0}, '{5, 8'h00, 3'h4, 2},
    '{6, 8'h09, 3'h0, 2}, '{9, 8'h00, 3'h4, 2}};
  lst_startup #(.TIMER_CYCLES(TC)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .av_address(av_address), .av_read(av_read), .av_write(av_write),
    .av_byteenable(4'hF), .av_writedata(av_writedata),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .rx_ctrl_valid(rx_v), .rx_ctrl_idx(rx_i), .rx_ctrl_byte(rx_b),
    .tx_ctrl_idx(tx_i), .tx_ctrl_byte(tx_b), .hyperframe_sync(hsync),
    .line_rate_match(1'b1), .signal_absent(fault[2]),
    .frame_lock_lost(fault[1]), .remote_alarm_flag(fault[0]),
    .slave_in_negotiation(1'b0), .app_new_mgmt_rate(app[4]),
    .app_accept(app[3]), .app_renegotiate(app[2]), .app_mgmt_lost(app[1]),
    .app_new_proto_rate(app[0]), .state_code(state_code),
    .scramble_on(scramble_on));
  lst_peer PEER (.ref_clk(ref_clk), .rst_n(rst_n), .p_ver(p_ver),
    .p_slow(p_slow), .p_fast(8'h00), .rx_ctrl_valid(rx_v),
    .rx_ctrl_idx(rx_i), .rx_ctrl_byte(rx_b));
  // clock, index sweep, timeout
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tx_i <= tx_i + 8'h01;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask
  // request held until wait sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    av_address <= a;
    av_write <= w;
    av_read <= !w;
    av_writedata <= d;
    do @(posedge ref_clk); while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_read <= 1'b0;
    av_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic step(input int op, input logic [7:0] v);
    case (op)
      0: p_ver <= v;
      1: p_slow <= v;
      3: hsync <= v[0];
      4: app <= v[4:0];
      5: begin fault <= v[2:0]; hsync <= !v; end
      6: bus(1'b1, REG_CTRL, {24'h0, v});
      default: ;
    endcase
    @(posedge ref_clk);
    app <= 5'h00;
  endtask
  // ***
  // sequence
  // ***
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rr[i]) begin
      bus(1'b0, rr[i].a, 32'h0);
      chk("reset", rr[i].r, q);
    end
    bus(1'b1, REG_CTRL, 32'h7);
    repeat (8) @(posedge ref_clk);
    chk("standby", 32'h0, {29'h0, state_code});
    foreach (rw[i]) begin
      bus(1'b1, rw[i].a, rw[i].w);
      bus(1'b0, rw[i].a, 32'h0);
      chk("reg", rw[i].r, q);
    end
    foreach (sr[i]) begin
      step(sr[i].op, sr[i].v);
      for (int k = 0; k < 300 && state_code !== sr[i].st; k++) @(posedge ref_clk);
      chk("state", {29'h0, sr[i].st}, {29'h0, state_code});
      if (sr[i].tm != 2) begin
        bus(1'b0, REG_STATUS, 32'h0);
        chk("timer", 32'(sr[i].tm), {31'h0, q[3]});
      end
    end
    chk("scramble", 32'h1, {31'h0, scramble_on});
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("reset state", 32'h0, {29'h0, state_code});
    end_of_test();
  end
endmodule  // tb_link_startup_transitions
`default_nettype wire
